/* src/ext_mem_interface_config.sv */
`default_nettype none
module ext_mem_interface_config
   import ext_mem_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                nrst,
   input  wire logic                legacyMode,
   input  wire logic                regWrite,
   input  wire logic [7:0]          regAddr,
   input  wire logic [7:0]          regWdata,
   output logic      [7:0]          regRdata,
   input  wire logic                accessValid,
   input  wire logic [15:0]         accessAddr,
   input  wire logic                adDriven,
   input  wire logic [7:0]          adPinIn,
   input  wire logic [7:0]          portDirection,
   output logic                     memPinsOwned,
   output logic      [7:0]          highAddrOwned,
   output logic      [7:0]          portDirEffective,
   output logic      [15:0]         maskedAddr,
   output logic                     upperSelected,
   output logic      [2:0]          strobeWaits,
   output logic                     addrHoldCycle,
   output logic                     keeperActive,
   output logic      [7:0]          keeperOut,
   output logic                     keeperOe
);
   // ==========================================================
   // Pin input synchroniser
   logic [7:0] adMeta_r, adSync_r;
   logic       drvMeta_r, drvSync_r;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         adMeta_r  <= 8'h00;
         adSync_r  <= 8'h00;
         drvMeta_r <= 1'b0;
         drvSync_r <= 1'b0;
      end else begin
         adMeta_r  <= adPinIn;
         adSync_r  <= adMeta_r;
         drvMeta_r <= adDriven;
         drvSync_r <= drvMeta_r;
      end
   end

   // ==========================================================
   // Registers
   logic [7:0] mcuCtl_r, mcuCtl_nxt;
   logic [7:0] xmcA_r, xmcA_nxt;
   logic [7:0] xmcB_r, xmcB_nxt;
   logic [7:0] rdata_nxt;
   always_comb begin
      mcuCtl_nxt = mcuCtl_r;
      xmcA_nxt   = xmcA_r;
      xmcB_nxt   = xmcB_r;
      if (regWrite) begin
         case (regAddr)
            MCU_CONTROL_OFS: mcuCtl_nxt = regWdata;
            XMC_A_OFS:       xmcA_nxt   = regWdata & XMC_A_MASK;
            XMC_B_OFS:       xmcB_nxt   = regWdata & XMC_B_MASK;
            default:         ;
         endcase
      end
      case (regAddr)
         MCU_CONTROL_OFS: rdata_nxt = mcuCtl_nxt;
         XMC_A_OFS:       rdata_nxt = xmcA_nxt;
         XMC_B_OFS:       rdata_nxt = xmcB_nxt;
         default:         rdata_nxt = 8'h00;
      endcase
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mcuCtl_r <= REG_RESET;
         xmcA_r   <= REG_RESET;
         xmcB_r   <= REG_RESET;
         regRdata <= REG_RESET;
      end else begin
         mcuCtl_r <= mcuCtl_nxt;
         xmcA_r   <= xmcA_nxt;
         xmcB_r   <= xmcB_nxt;
         regRdata <= rdata_nxt;
      end
   end

   // ==========================================================
   // Configuration fields
   xmem_cfg_s cfg;
   always_comb begin
      cfg.enable       = mcuCtl_r[ENABLE_BIT];
      cfg.upperWaitLo  = mcuCtl_r[UPPER_WAIT_LO];
      cfg.legacyMode   = legacyMode;
      cfg.sectorLimit  = xmcA_r[SECTOR_LIM_LSB +: 3];
      cfg.lowerWait    = xmcA_r[LOWER_WAIT_LSB +: 2];
      cfg.upperWaitHi  = xmcA_r[UPPER_WAIT_HI];
      cfg.keeperEnable = xmcB_r[KEEPER_BIT];
      cfg.highMask     = xmcB_r[HIGH_MASK_LSB +: 3];
   end

   // ==========================================================
   // Sector select and wait decode
   logic [15:0] upperBase;
   logic        inUpper;
   logic [1:0]  selCode;
   wait_cfg_s   waitCfg;
   always_comb begin
      upperBase = 16'({cfg.sectorLimit, 13'h0000});
      if (cfg.sectorLimit == 3'd0) begin
         inUpper = 1'b1;
      end else begin
         inUpper = (accessAddr >= upperBase);
      end
      if (inUpper) begin
         selCode = {cfg.upperWaitHi, cfg.upperWaitLo};
      end else begin
         selCode = cfg.lowerWait;
      end
   end
   wait_decode u_wait_decode (
      .code       (selCode),
      .legacyMode (cfg.legacyMode),
      .legacyBit  (cfg.upperWaitLo),
      .cfg        (waitCfg)
   );

   // ==========================================================
   // Pin ownership, mask and keeper
   logic [7:0]  highOwn_nxt, dirEff_nxt, keepOut_nxt;
   logic [15:0] mAddr_nxt;
   logic        keepOe_nxt;
   always_comb begin
      highOwn_nxt = 8'hFF >> cfg.highMask;
      if (!cfg.enable) begin
         highOwn_nxt = 8'h00;
      end
      // Direction override: owned pins driven by interface
      dirEff_nxt = cfg.enable ? (portDirection | highOwn_nxt)
                              : portDirection;
      // Masked address: high byte gated by owned pins, low byte passes unmasked
      mAddr_nxt = {accessAddr[15:8] & highOwn_nxt,
                   accessAddr[7:0]};
      keepOe_nxt  = cfg.keeperEnable && !drvSync_r;
      keepOut_nxt = keeperOut;
      if (drvSync_r) begin
         keepOut_nxt = adSync_r;
      end
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         memPinsOwned     <= 1'b0;
         highAddrOwned    <= 8'h00;
         portDirEffective <= 8'h00;
         maskedAddr       <= 16'h0000;
         upperSelected    <= 1'b0;
         strobeWaits      <= 3'd0;
         addrHoldCycle    <= 1'b0;
         keeperActive     <= 1'b0;
         keeperOut        <= 8'h00;
         keeperOe         <= 1'b0;
      end else begin
         memPinsOwned     <= cfg.enable;
         highAddrOwned    <= highOwn_nxt;
         portDirEffective <= dirEff_nxt;
         maskedAddr       <= mAddr_nxt;
         upperSelected    <= accessValid && inUpper;
         strobeWaits      <= accessValid ? waitCfg.strobeWaits : 3'd0;
         addrHoldCycle    <= accessValid && waitCfg.holdCycle;
         keeperActive     <= cfg.keeperEnable;
         keeperOut        <= keepOut_nxt;
         keeperOe         <= keepOe_nxt;
      end
   end

   // ==========================================================
   // Checks
   sequence legacy_access_s;
      accessValid && legacyMode;
   endsequence
   chk_enable_owns: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      memPinsOwned == $past(mcuCtl_r[ENABLE_BIT]))
      else $error("pin ownership does not follow enable");
   chk_dir_override: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      memPinsOwned |-> (portDirEffective & highAddrOwned) == highAddrOwned)
      else $error("direction not overridden");
   chk_release_pins: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !memPinsOwned |-> highAddrOwned == 8'h00)
      else $error("pins kept while disabled");
   chk_single_sector: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      (accessValid && xmcA_r[6:4] == 3'h0) |=> upperSelected)
      else $error("single sector not upper");
   chk_sector_limit: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      (accessValid && xmcA_r[6:4] != 3'h0 &&
       accessAddr < {xmcA_r[6:4], 13'h0000}) |=> !upperSelected)
      else $error("lower sector misdecoded");
   chk_hold_code: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      addrHoldCycle |-> strobeWaits == 3'h2)
      else $error("hold without two waits");
   chk_legacy_wait: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      legacy_access_s |=>
      strobeWaits == {2'h0, $past(mcuCtl_r[UPPER_WAIT_LO])} &&
      !addrHoldCycle)
      else $error("legacy wait not from upper wait low bit");
   chk_mask_width: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      (memPinsOwned && $stable(xmcB_r) && $past(memPinsOwned))
      |-> highAddrOwned == (8'hFF >> xmcB_r[2:0]))
      else $error("mask width wrong");
   chk_keeper_free: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      keeperActive == $past(xmcB_r[KEEPER_BIT]))
      else $error("keeper does not follow its bit");
   chk_keeper_gate: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      keeperOe == ($past(xmcB_r[KEEPER_BIT]) && !$past(drvSync_r)))
      else $error("keeper drive gating wrong");
   chk_keeper_hold: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      (keeperOe && $past(keeperOe)) |-> $stable(keeperOut))
      else $error("keeper level not held");
endmodule : ext_mem_interface_config
`default_nettype wire

/* src/ext_mem_pkg.sv */
`default_nettype none
package ext_mem_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] MCU_CONTROL_OFS = 8'h35;
   localparam logic [7:0] XMC_B_OFS       = 8'h6C;
   localparam logic [7:0] XMC_A_OFS       = 8'h6D;
   // ==========================================================
   // Reset values and field positions
   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam int ENABLE_BIT      = 7;
   localparam int UPPER_WAIT_LO   = 6;
   localparam int SECTOR_LIM_LSB  = 4;
   localparam int LOWER_WAIT_LSB  = 2;
   localparam int UPPER_WAIT_HI   = 1;
   localparam int KEEPER_BIT      = 7;
   localparam int HIGH_MASK_LSB   = 0;
   // Writable bit masks
   localparam logic [7:0] XMC_A_MASK      = 8'h7E;
   localparam logic [7:0] XMC_B_MASK      = 8'h87;
   localparam logic [7:0] MCU_EXT_MASK    = 8'hC0;
   // ==========================================================
   // Address space
   localparam logic [15:0] EXT_BASE       = 16'h1100;
   localparam logic [15:0] SECTOR_STEP    = 16'h2000;
   localparam int HIGH_BITS       = 8;

   typedef enum logic [1:0] {
      WAIT_NONE, WAIT_ONE, WAIT_TWO, WAIT_TWO_HOLD
   } wait_code_e;

   typedef struct packed {
      logic [2:0] strobeWaits;
      logic       holdCycle;
   } wait_cfg_s;

   typedef struct packed {
      logic       enable;
      logic       upperWaitLo;
      logic       legacyMode;
      logic [2:0] sectorLimit;
      logic [1:0] lowerWait;
      logic       upperWaitHi;
      logic       keeperEnable;
      logic [2:0] highMask;
   } xmem_cfg_s;
endpackage : ext_mem_pkg
`default_nettype wire

/* src/wait_decode.sv */
`default_nettype none
module wait_decode
   import ext_mem_pkg::*;
(
   input  wire logic [1:0]            code,
   input  wire logic                  legacyMode,
   input  wire logic                  legacyBit,
   output var ext_mem_pkg::wait_cfg_s cfg
);
   // ==========================================================
   // Wait code decode
   always_comb begin
      cfg = '0;
      if (legacyMode) begin
         cfg.strobeWaits = {2'b00, legacyBit};
      end else begin
         case (wait_code_e'(code))
            WAIT_NONE:     cfg.strobeWaits = 3'd0;
            WAIT_ONE:      cfg.strobeWaits = 3'd1;
            WAIT_TWO:      cfg.strobeWaits = 3'd2;
            WAIT_TWO_HOLD: begin
               cfg.strobeWaits = 3'd2;
               cfg.holdCycle   = 1'b1;
            end
            default:       cfg.strobeWaits = 3'd0;
         endcase
      end
   end
endmodule : wait_decode
`default_nettype wire

/* verification/ext_mem_interface_config_tb.sv */
`default_nettype none
module ext_mem_interface_config_tb;
   import ext_mem_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0]  mcu, xa, xb;
      logic [15:0] addr;
      logic        up;
      logic [2:0]  w;
      logic        hold;
      logic [7:0]  own;
   } row_s;
   logic        sys_clk, nrst, legacyMode, regWrite, accessValid;
   logic        busDrive, adDriven, memPinsOwned, upperSelected;
   logic        addrHoldCycle, keeperActive, keeperOe;
   logic [7:0]  regAddr, regWdata, regRdata, adPinIn, busVal;
   logic [7:0]  portDirection, highAddrOwned, portDirEffective, keeperOut;
   logic [15:0] accessAddr, maskedAddr;
   logic [2:0]  strobeWaits;
   int          numErrors, nChecks;
   row_s        r;
   row_s        rows[8] = '{
      '{8'h80, 8'h00, 8'h00, 16'h1100, 1'h1, 3'h0, 1'h0, 8'hFF},
      '{8'hC0, 8'h83, 8'h00, 16'hFFFF, 1'h1, 3'h2, 1'h1, 8'hFF},
      '{8'h80, 8'h1C, 8'h79, 16'h1FFF, 1'h0, 3'h2, 1'h1, 8'h7F},
      '{8'h80, 8'h14, 8'h03, 16'h2000, 1'h1, 3'h0, 1'h0, 8'h1F},
      '{8'h40, 8'h78, 8'h07, 16'hDFFF, 1'h0, 3'h2, 1'h0, 8'h00},
      '{8'hC0, 8'h70, 8'h04, 16'hE000, 1'h1, 3'h1, 1'h0, 8'h0F},
      '{8'h80, 8'h26, 8'h02, 16'h3FFF, 1'h0, 3'h1, 1'h0, 8'h3F},
      '{8'h80, 8'h50, 8'h06, 16'hA000, 1'h1, 3'h0, 1'h0, 8'h03}
   };
   // =========================================================
   // Design and memory model
   ext_mem_interface_config i_ext_mem_interface_config (
      .sys_clk, .nrst, .legacyMode, .regWrite, .regAddr, .regWdata,
      .regRdata, .accessValid, .accessAddr, .adDriven, .adPinIn,
      .portDirection, .memPinsOwned, .highAddrOwned, .portDirEffective,
      .maskedAddr, .upperSelected, .strobeWaits, .addrHoldCycle,
      .keeperActive, .keeperOut, .keeperOe
   );
   ext_mem_partner i_ext_mem_partner (
      .sys_clk, .busDrive, .busVal, .adDriven, .adPinIn
   );
   // =========================================================
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("Error %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      regWrite = 1'h1;
      regAddr  = a;
      regWdata = d;
      @(negedge sys_clk);
      regWrite = 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      regAddr = a;
      @(negedge sys_clk);
      chk({8'h00, regRdata}, {8'h00, e});
   endtask : rd
   task automatic acc(input logic v, input logic [15:0] a);
      @(negedge sys_clk);
      accessValid = v;
      accessAddr  = a;
      repeat (3) @(negedge sys_clk);
   endtask : acc
   task automatic print_verdict;
      $display("Checks %0d, errors %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   // =========================================================
   // Clock, watchdog, tests
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      #200000;
      numErrors++;
      print_verdict();
   end
   initial begin
      {nrst, legacyMode, regWrite, accessValid, busDrive} = 5'h00;
      {regAddr, regWdata, busVal, accessAddr} = 40'h0;
      portDirection = 8'h0F;
      repeat (2) @(negedge sys_clk);
      nrst = 1'h1;
      rd(MCU_CONTROL_OFS, 8'h00);
      rd(XMC_A_OFS, 8'h00);
      rd(XMC_B_OFS, 8'h00);
      wr(8'h36, 8'hFF);
      rd(8'h36, 8'h00);
      foreach (rows[i]) begin
         r = rows[i];
         wr(MCU_CONTROL_OFS, r.mcu);
         wr(XMC_A_OFS, r.xa);
         wr(XMC_B_OFS, r.xb);
         rd(XMC_A_OFS, r.xa & XMC_A_MASK);
         rd(XMC_B_OFS, r.xb & XMC_B_MASK);
         acc(1'h1, r.addr);
         chk(16'(memPinsOwned), 16'(r.mcu[7]));
         chk(16'(highAddrOwned), 16'(r.own));
         chk(16'(portDirEffective), 16'(r.own | 8'h0F));
         chk(maskedAddr, {r.addr[15:8] & r.own, r.addr[7:0]});
         chk(16'(upperSelected), 16'(r.up));
         chk(16'(strobeWaits), 16'(r.w));
         chk(16'(addrHoldCycle), 16'(r.hold));
      end
      acc(1'h0, 16'hFFFF);
      chk(16'(strobeWaits), 16'h0000);
      chk(16'(upperSelected), 16'h0000);
      chk(16'(addrHoldCycle), 16'h0000);
      legacyMode = 1'h1;
      wr(MCU_CONTROL_OFS, 8'h40);
      wr(XMC_A_OFS, 8'h1C);
      acc(1'h1, 16'h1200);
      chk(16'(strobeWaits), 16'h0001);
      chk(16'(addrHoldCycle), 16'h0000);
      wr(MCU_CONTROL_OFS, 8'h00);
      acc(1'h1, 16'h1200);
      chk(16'(strobeWaits), 16'h0000);
      legacyMode = 1'h0;
      wr(XMC_B_OFS, 8'h80);
      busVal   = 8'hA5;
      busDrive = 1'h1;
      repeat (5) @(negedge sys_clk);
      chk(16'(keeperOe), 16'h0000);
      busDrive = 1'h0;
      repeat (5) @(negedge sys_clk);
      chk(16'(keeperOe), 16'h0001);
      chk(16'(keeperOut), 16'h00A5);
      chk(16'(keeperActive), 16'h0001);
      chk(16'(memPinsOwned), 16'h0000);
      wr(XMC_B_OFS, 8'h00);
      repeat (4) @(negedge sys_clk);
      chk(16'(keeperOe), 16'h0000);
      wr(MCU_CONTROL_OFS, 8'h80);
      wr(XMC_A_OFS, 8'h7E);
      wr(XMC_B_OFS, 8'h87);
      rd(MCU_CONTROL_OFS, 8'h80);
      nrst = 1'h0;
      @(negedge sys_clk);
      nrst = 1'h1;
      rd(MCU_CONTROL_OFS, 8'h00);
      rd(XMC_A_OFS, 8'h00);
      rd(XMC_B_OFS, 8'h00);
      chk(16'(memPinsOwned), 16'h0000);
      chk(16'(keeperActive), 16'h0000);
      chk(16'(highAddrOwned), 16'h0000);
      print_verdict();
   end
endmodule : ext_mem_interface_config_tb
`default_nettype wire

/* verification/ext_mem_partner.sv */
`default_nettype none
module ext_mem_partner (
   input  wire logic       sys_clk,
   input  wire logic       busDrive,
   input  wire logic [7:0] busVal,
   output var  logic       adDriven,
   output var  logic [7:0] adPinIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] lastVal;
   // =========================================================
   // Memory drives muxed lines, then floats away from last value
   initial begin
      adDriven = 1'h0;
      adPinIn  = 8'h00;
      lastVal  = 8'h00;
   end
   always @(posedge sys_clk) begin
      adDriven <= busDrive;
      lastVal  <= busDrive ? busVal : lastVal;
      adPinIn  <= busDrive ? busVal : ~lastVal;
   end
endmodule : ext_mem_partner
`default_nettype wire
